// [rtl/rfs_consts.vh]
`ifndef RFS_CONSTS_VH
`define RFS_CONSTS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define RFS_ADDR_W 6
`define RFS_OFS_FAULT 6'h0d
`define RFS_OFS_PINMON 6'h0e
`define RFS_RST_FAULT 16'h0000
`define RFS_RST_PINMON 16'h0000
// ----------------------------------------
// Fault word fields
// ----------------------------------------
`define RFS_B_CLAMP 15
`define RFS_B_CFGCRC 14
`define RFS_B_USRCRC 13
`define RFS_B_TRMCRC 12
`define RFS_B_ILIM 11
`define RFS_B_UV 10
`define RFS_B_OV 9
`define RFS_B_LOOPE 8
`define RFS_B_COSL 7
`define RFS_B_SINL 6
`define RFS_B_COSH 5
`define RFS_B_SINH 4
`define RFS_B_LINK_HI 3
`define RFS_B_LINK_LO 2
`define RFS_B_GND 1
`define RFS_B_SHORT 0
// ----------------------------------------
// Link status codes
// ----------------------------------------
`define RFS_LINK_OK 2'h0
`define RFS_LINK_CRC 2'h1
`define RFS_LINK_MISM 2'h2
`define RFS_LINK_ADDR 2'h3
// ----------------------------------------
// Pin monitor fields
// ----------------------------------------
`define RFS_B_AUX 14
`define RFS_PAR_W 14
`endif

// [rtl/rfs_fault_status_regs.v]
// Behaviour
// - Bit 15 tracker clamp, clear on read
// - Bit 14 config CRC error, clear on read
// - Bit 13 user memory CRC, clear on read
// - Bit 12 trim memory CRC, clear on read
// - Bit 11 exciter current limit, clear on read
// - Bit 10 exciter undervoltage, clear on read
// - Bit 9 exciter overvoltage, clear on read
// - Bit 8 tracking loop error, clear on read
// - Cosine low open bit 7, high bit 5
// - Sine low open bit 6, high bit 4
// - Bits 3-2 carry serial link status code
// - Link code of previous frame, zero after read
// - Bit 1 ground open, clear on read
// - Bit 0 sensor input short, clear on read
// - Fault word at 0xD, resets zero
// - Pin monitor at 0xE, resets zero
// - Bit 14 shows aux output pin level
// - Bits 13-0 show parallel output pins
// - Undervoltage disables exciter unless override set
// - Register access in diagnostic and normal states
`timescale 1ns/10ps
`include "rfs_consts.vh"
module rfs_fault_status_regs #(
  parameter PAR_W = `RFS_PAR_W
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_arst_n,
  // Register port from serial interface logic
  input wire i_reg_rd,
  input wire i_reg_wr,
  input wire [`RFS_ADDR_W-1:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_diagnostic_state,
  output reg [15:0] o_reg_rdata,
  // Fault event levels from detectors
  input wire i_tracker_clamp_flag,
  input wire i_config_crc_error,
  input wire i_user_nvm_crc_error,
  input wire i_trim_nvm_crc_error,
  input wire i_exciter_current_limit_fault,
  input wire i_exciter_undervolt_fault,
  input wire i_exciter_overvolt_fault,
  input wire i_tracker_error_fault,
  input wire i_cosine_low_open_fault,
  input wire i_sine_low_open_fault,
  input wire i_cosine_high_open_fault,
  input wire i_sine_high_open_fault,
  input wire i_ground_open_fault,
  input wire i_sense_input_short_fault,
  // Serial link frame result
  input wire i_frame_end,
  input wire [1:0] i_frame_status,
  // Exciter control
  input wire i_keep_exciter_on_undervolt,
  input wire i_exciter_enable_req,
  output reg o_exciter_enable,
  // Output pins to monitor
  input wire i_aux_output_pin,
  input wire [PAR_W-1:0] i_parallel_output_pins
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [PAR_W:0] pin_s1_r;
reg [PAR_W:0] pin_s2_r;

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    pin_s1_r <= {(PAR_W+1){1'h0}};
    pin_s2_r <= {(PAR_W+1){1'h0}};
  end else begin
    pin_s1_r <= {i_aux_output_pin, i_parallel_output_pins};
    pin_s2_r <= pin_s1_r;
  end
end

// ----------------------------------------
// Reset values
// ----------------------------------------
localparam [15:0] FAULT_RST = `RFS_RST_FAULT;
localparam [15:0] PINMON_RST = `RFS_RST_PINMON;

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Clear-on-read flag: read clears, live fault sets again
function rfs_rc_next;
  input cur;
  input fault_in;
  input clr;
  begin
    rfs_rc_next = (cur && !clr) || fault_in;
  end
endfunction

// Read strobe aimed at one register offset
function rfs_hit;
  input rd;
  input [`RFS_ADDR_W-1:0] addr;
  input [`RFS_ADDR_W-1:0] ofs;
  begin
    rfs_hit = rd && (addr == ofs);
  end
endfunction

// ----------------------------------------
// Register decode
// ----------------------------------------
wire rd_fault;
wire rd_pinmon;

// Reads honoured in any operating state
assign rd_fault = rfs_hit(i_reg_rd, i_reg_addr, `RFS_OFS_FAULT);
assign rd_pinmon = rfs_hit(i_reg_rd, i_reg_addr, `RFS_OFS_PINMON);

// ----------------------------------------
// Latched fault flags
// ----------------------------------------
// One flop per flag; a live fault beats the clearing read
reg clamp_r;
reg cfg_crc_r;
reg usr_crc_r;
reg trm_crc_r;
reg ilim_r;
reg uv_r;
reg ov_r;
reg loop_err_r;
reg cos_low_r;
reg sin_low_r;
reg cos_high_r;
reg sin_high_r;
reg gnd_open_r;
reg short_r;

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    clamp_r <= FAULT_RST[`RFS_B_CLAMP];
  end else begin
    clamp_r <= rfs_rc_next(clamp_r, i_tracker_clamp_flag, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    cfg_crc_r <= FAULT_RST[`RFS_B_CFGCRC];
  end else begin
    cfg_crc_r <= rfs_rc_next(cfg_crc_r, i_config_crc_error, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    usr_crc_r <= FAULT_RST[`RFS_B_USRCRC];
  end else begin
    usr_crc_r <= rfs_rc_next(usr_crc_r, i_user_nvm_crc_error, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    trm_crc_r <= FAULT_RST[`RFS_B_TRMCRC];
  end else begin
    trm_crc_r <= rfs_rc_next(trm_crc_r, i_trim_nvm_crc_error, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    ilim_r <= FAULT_RST[`RFS_B_ILIM];
  end else begin
    ilim_r <= rfs_rc_next(ilim_r, i_exciter_current_limit_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    uv_r <= FAULT_RST[`RFS_B_UV];
  end else begin
    uv_r <= rfs_rc_next(uv_r, i_exciter_undervolt_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    ov_r <= FAULT_RST[`RFS_B_OV];
  end else begin
    ov_r <= rfs_rc_next(ov_r, i_exciter_overvolt_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    loop_err_r <= FAULT_RST[`RFS_B_LOOPE];
  end else begin
    loop_err_r <= rfs_rc_next(loop_err_r, i_tracker_error_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    cos_low_r <= FAULT_RST[`RFS_B_COSL];
  end else begin
    cos_low_r <= rfs_rc_next(cos_low_r, i_cosine_low_open_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    sin_low_r <= FAULT_RST[`RFS_B_SINL];
  end else begin
    sin_low_r <= rfs_rc_next(sin_low_r, i_sine_low_open_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    cos_high_r <= FAULT_RST[`RFS_B_COSH];
  end else begin
    cos_high_r <= rfs_rc_next(cos_high_r, i_cosine_high_open_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    sin_high_r <= FAULT_RST[`RFS_B_SINH];
  end else begin
    sin_high_r <= rfs_rc_next(sin_high_r, i_sine_high_open_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    gnd_open_r <= FAULT_RST[`RFS_B_GND];
  end else begin
    gnd_open_r <= rfs_rc_next(gnd_open_r, i_ground_open_fault, rd_fault);
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    short_r <= FAULT_RST[`RFS_B_SHORT];
  end else begin
    short_r <= rfs_rc_next(short_r, i_sense_input_short_fault, rd_fault);
  end
end

// ----------------------------------------
// Serial link status code
// ----------------------------------------
reg [1:0] link_r;
reg [1:0] link_nxt;

always @* begin
  // Hold the last frame's code by default
  link_nxt = link_r;
  if (rd_fault) begin
    link_nxt = `RFS_LINK_OK;
  end
  // Frame result in the read cycle is not lost
  if (i_frame_end) begin
    link_nxt = i_frame_status;
  end
end

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    link_r <= FAULT_RST[`RFS_B_LINK_HI:`RFS_B_LINK_LO];
  end else begin
    link_r <= link_nxt;
  end
end

// ----------------------------------------
// Fault word assembly
// ----------------------------------------
wire [15:0] fault_word;

assign fault_word[`RFS_B_CLAMP] = clamp_r;
assign fault_word[`RFS_B_CFGCRC] = cfg_crc_r;
assign fault_word[`RFS_B_USRCRC] = usr_crc_r;
assign fault_word[`RFS_B_TRMCRC] = trm_crc_r;
assign fault_word[`RFS_B_ILIM] = ilim_r;
assign fault_word[`RFS_B_UV] = uv_r;
assign fault_word[`RFS_B_OV] = ov_r;
assign fault_word[`RFS_B_LOOPE] = loop_err_r;
assign fault_word[`RFS_B_COSL] = cos_low_r;
assign fault_word[`RFS_B_SINL] = sin_low_r;
assign fault_word[`RFS_B_COSH] = cos_high_r;
assign fault_word[`RFS_B_SINH] = sin_high_r;
assign fault_word[`RFS_B_LINK_HI:`RFS_B_LINK_LO] = link_r;
assign fault_word[`RFS_B_GND] = gnd_open_r;
assign fault_word[`RFS_B_SHORT] = short_r;

// ----------------------------------------
// Pin monitor word
// ----------------------------------------
wire [15:0] pinmon_word;

assign pinmon_word[15] = PINMON_RST[15];
assign pinmon_word[`RFS_B_AUX] = pin_s2_r[PAR_W];
assign pinmon_word[PAR_W-1:0] = pin_s2_r[PAR_W-1:0];

// ----------------------------------------
// Exciter undervoltage shutdown
// ----------------------------------------
wire uv_shutdown;

assign uv_shutdown = i_exciter_undervolt_fault && !i_keep_exciter_on_undervolt;

always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    o_exciter_enable <= 1'h0;
  end else begin
    o_exciter_enable <= i_exciter_enable_req && !uv_shutdown;
  end
end

// ----------------------------------------
// Read data
// ----------------------------------------
always @(posedge i_clk_sys or negedge i_arst_n) begin
  if (!i_arst_n) begin
    o_reg_rdata <= 16'h0000;
  end else if (rd_fault) begin
    o_reg_rdata <= fault_word;
  end else if (rd_pinmon) begin
    o_reg_rdata <= pinmon_word;
  end else if (i_reg_rd) begin
    // Unmapped index reads as zero
    o_reg_rdata <= 16'h0000;
  end
end

// Writes (i_reg_wr, i_reg_wdata) to either word have no effect
wire unused_ok;
assign unused_ok = i_reg_wr | (|i_reg_wdata) | i_diagnostic_state;

endmodule

// [bench/rfs_host_model.sv]
`timescale 1ns/10ps
module rfs_host_model (
  input wire i_clk_sys,
  input wire [15:0] i_rdata,
  output reg o_rd = 1'b0,
  output reg o_wr = 1'b0,
  output reg [5:0] o_addr = 6'h00,
  output reg [15:0] o_wdata = 16'h0000
);
  // Reads work in either device state
  task rd(input [5:0] a, output [15:0] d);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk_sys);
    d = i_rdata;
  endtask
  task wr(input [5:0] a, input [15:0] v);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = v;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_wdata = ~v;
  endtask
  task idle(input integer n);
    o_rd = 1'b0;
    o_addr = ~o_addr;
    repeat (n) @(negedge i_clk_sys);
  endtask
endmodule

// [bench/rfs_fault_status_regs_props.sv]
`timescale 1ns/10ps
module rfs_fault_status_regs_props #(parameter PAR_W = 14) (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire i_reg_rd,
  input wire [5:0] i_reg_addr,
  input wire [15:0] o_reg_rdata,
  input wire i_tracker_clamp_flag,
  input wire i_exciter_undervolt_fault,
  input wire i_keep_exciter_on_undervolt,
  input wire i_exciter_enable_req,
  input wire o_exciter_enable,
  input wire i_frame_end,
  input wire [1:0] i_frame_status,
  input wire i_aux_output_pin,
  input wire [PAR_W-1:0] i_parallel_output_pins
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  wire rf = i_reg_rd && i_reg_addr == 6'h0d;
  wire rp = i_reg_rd && i_reg_addr == 6'h0e;
  wire fe = i_frame_end;
  wire [14:0] pins = {i_aux_output_pin, i_parallel_output_pins};
  property p_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_rsv; rp |=> !o_reg_rdata[15]; endproperty
  a_rsv: assert property (p_rsv) else $error("bit 15 set");
  property p_set; i_tracker_clamp_flag ##1 rf |=> o_reg_rdata[15]; endproperty
  a_set: assert property (p_set) else $error("clamp lost");
  property p_clr;
    rf && !i_tracker_clamp_flag ##1 rf && !i_tracker_clamp_flag |=> !o_reg_rdata[15];
  endproperty
  a_clr: assert property (p_clr) else $error("clamp kept");
  property p_uv; i_exciter_undervolt_fault && !i_keep_exciter_on_undervolt |=> !o_exciter_enable; endproperty
  a_uv: assert property (p_uv) else $error("exciter on");
  property p_en;
    i_exciter_enable_req && (!i_exciter_undervolt_fault || i_keep_exciter_on_undervolt) |=> o_exciter_enable;
  endproperty
  a_en: assert property (p_en) else $error("exciter off");
  property p_pin; $stable(pins)[*2] ##0 rp |=> o_reg_rdata[14:0] == $past(pins); endproperty
  a_pin: assert property (p_pin) else $error("pin levels");
  property p_link; fe ##1 !fe && !i_reg_rd ##1 rf && !fe |=> o_reg_rdata[3:2] == $past(i_frame_status, 3); endproperty
  a_link: assert property (p_link) else $error("link code");
  property p_link0; rf && !fe ##1 !fe[*2] ##1 rf && !fe |=> o_reg_rdata[3:2] == 2'h0; endproperty
  a_link0: assert property (p_link0) else $error("link kept");
  c_rd: cover property (rf ##1 rf);
  c_link: cover property (fe && i_frame_status == 2'h3);
  c_keep: cover property (i_exciter_undervolt_fault && i_keep_exciter_on_undervolt);
endmodule
bind rfs_fault_status_regs rfs_fault_status_regs_props #(.PAR_W(PAR_W)) u_rfs_fault_status_regs_props (
  .i_clk_sys, .i_arst_n, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .i_tracker_clamp_flag,
  .i_exciter_undervolt_fault, .i_keep_exciter_on_undervolt, .i_exciter_enable_req,
  .o_exciter_enable, .i_frame_end, .i_frame_status, .i_aux_output_pin, .i_parallel_output_pins);

// [bench/rfs_fault_status_regs_tb.sv]
`timescale 1ns/10ps
module rfs_fault_status_regs_tb;
  reg clk, rst_n, fe, keep, req, aux, diagnostic_state;
  reg [15:0] f;
  reg [13:0] par;
  reg [1:0] fs;
  reg [15:0] d;
  wire rd, wr, en;
  wire [5:0] addr;
  wire [15:0] wd, rdata;
  integer n_mismatch = 0, tests_run = 0, b;
  rfs_host_model u_host (.i_clk_sys(clk), .i_rdata(rdata), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wd));
  rfs_fault_status_regs u_rfs_fault_status_regs (.i_clk_sys(clk), .i_arst_n(rst_n), .i_reg_rd(rd),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .i_diagnostic_state(diagnostic_state), .o_reg_rdata(rdata),
    .i_tracker_clamp_flag(f[15]), .i_config_crc_error(f[14]), .i_user_nvm_crc_error(f[13]),
    .i_trim_nvm_crc_error(f[12]), .i_exciter_current_limit_fault(f[11]), .i_exciter_undervolt_fault(f[10]),
    .i_exciter_overvolt_fault(f[9]), .i_tracker_error_fault(f[8]), .i_cosine_low_open_fault(f[7]),
    .i_sine_low_open_fault(f[6]), .i_cosine_high_open_fault(f[5]), .i_sine_high_open_fault(f[4]),
    .i_ground_open_fault(f[1]), .i_sense_input_short_fault(f[0]), .i_frame_end(fe), .i_frame_status(fs),
    .i_keep_exciter_on_undervolt(keep), .i_exciter_enable_req(req), .o_exciter_enable(en),
    .i_aux_output_pin(aux), .i_parallel_output_pins(par));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task chk(input [15:0] g, input [15:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rc(input [5:0] a, input [15:0] e);
    u_host.rd(a, d);
    chk(d, e);
  endtask
  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000 n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    rst_n = 1'h0;
    {fe, keep, aux, diagnostic_state} = 4'h0;
    req = 1'h1;
    {f, par, fs} = 32'h0;
    repeat (4) @(negedge clk);
    rst_n = 1;
    rc(6'h0d, 16'h0000);
    rc(6'h0e, 16'h0000);
    u_host.idle(1);
    u_host.wr(6'h0d, 16'hffff);
    rc(6'h0d, 16'h0000);
    for (b = 0; b < 16; b = b + 1) if (b != 2 && b != 3) begin
      diagnostic_state = b[0];
      f = 16'h0001 << b;
      u_host.idle(1);
      f = 0;
      rc(6'h0d, 16'h0001 << b);
      rc(6'h0d, 16'h0000);
    end
    f = 16'h0400;
    keep = 1;
    u_host.idle(2);
    chk(en, 16'h0001);
    keep = 0;
    u_host.idle(1);
    chk(en, 16'h0000);
    keep = 1'h1;
    req = 1'h0;
    u_host.idle(1);
    chk(en, 16'h0000);
    req = 1'h1;
    keep = 1'h0;
    rc(6'h0d, 16'h0400);
    rc(6'h0d, 16'h0400);
    f = 0;
    rc(6'h0d, 16'h0400);
    rc(6'h0d, 16'h0000);
    for (b = 0; b < 4; b = b + 1) begin
      fs = b;
      fe = 1;
      u_host.idle(1);
      fe = 0;
      u_host.idle(1);
      rc(6'h0d, b << 2);
      u_host.idle(2);
      rc(6'h0d, 16'h0000);
    end
    aux = 1;
    par = 14'h2a5a;
    u_host.idle(2);
    rc(6'h0e, 16'h6a5a);
    aux = 0;
    par = 14'h3fff;
    u_host.idle(2);
    rc(6'h0e, 16'h3fff);
    summarize;
  end
endmodule
